/* File: core/clock_guard_and_stop_detect.sv */
// clock lock, oscillator stop and restart detection, and register write protection
//
// Overview of operation
// RULE1: clock lock ignores writes to guarded clock bits
// RULE2: software engages lock via mode unlock sequence
// RULE3: software avoids wait while clock locked
// RULE4: detection runs only with enable bit set
// RULE5: software keeps detection off below 2 MHz
// RULE6: stop with action zero forces halting reset
// RULE7: halting reset ends only by hardware reset
// RULE8: no enable with reset action while stopped
// RULE9: main source stop falls back to on-chip
// RULE10: pll source stop keeps oscillator select unchanged
// RULE11: restart sets flag, clears halted status
// RULE12: interrupt shared with watchdog, flag identifies
// RULE13: set flag suppresses further detect interrupts
// RULE14: low-speed stop moves peripherals to on-chip
// RULE15: software clears wait clock bit before wait
// RULE16: software disables detection before deliberate stops
// RULE17: four unlock bits gate four register groups
// RULE18: port unlock clears on next register write
// RULE19: other unlock bits stay until software clears
// RULE20: port write follows unlock without interruption
// RULE21: protected writes leave contents, no error
// RULE22: software disables detection before mode transitions
`timescale 1ns/1ps
module clock_guard_and_stop_detect
   import clock_guard_pkg::*;
(
   // clock and resets
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hwReset2_n,
   // register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata,
   // oscillator status
   input wire logic mainClkAlive,
   // detector results
   output logic stopDetectIrq,
   output logic oscStopResetHold,
   output logic onchipOscRun,
   output logic [1:0] cpuClkSrc,
   output logic [1:0] periphClkSrc,
   // clock controls to the clock tree, then the port-direction and voltage-control registers
   output logic periphClkInWait,
   output logic mainOscOff,
   output logic stopModeEntry,
   output logic [DATA_W-1:0] pllCtrl,
   output logic [DATA_W-1:0] portDir,
   output logic [DATA_W-1:0] voltageCtrl
);
   // hardware reset from either source
   logic hwReset;
   // internal initialisation, also taken during a halting reset
   logic init;
   // register state
   logic [DATA_W-1:0] clockControlRegZero;
   logic [DATA_W-1:0] clockControlRegOne;
   logic stopDetectEnable;
   logic internalOscSelect;
   logic stopDetectFlag;
   logic mainClockHalted;
   logic detectActionSelect;
   logic clockLockBit;
   logic lowSpeedFallback;
   // protect bits
   logic clockRegUnlock;
   logic modeRegUnlock;
   logic portRegUnlock;
   logic voltageRegUnlock;
   // decoded writes
   logic wrCm0;
   logic wrCm1;
   logic wrCm2;
   logic wrPlc0;
   logic wrPm2;
   logic wrPrcr;
   logic wrPort;
   logic wrVolt;
   // detector events
   logic stopSeen;
   logic restartSeen;
   logic eventAccepted;
   logic stopOnMain;
   logic stopOnPll;
   logic stopOnSub;
   logic [DATA_W-1:0] next_readValue;
   logic [DATA_W-1:0] clockControlRegTwo;

   // either hardware reset source restarts everything, the halting reset included
   assign hwReset = !rst_n || !hwReset2_n; // RULE7
   // a halting reset initialises the rest of the block, read data apart, while it stands
   assign init = hwReset || oscStopResetHold; // RULE6

   // address decoding of writes; each protect bit gates its own group
   always_comb begin
      wrCm0 = 1'b0;
      wrCm1 = 1'b0;
      wrCm2 = 1'b0;
      wrPlc0 = 1'b0;
      wrPm2 = 1'b0;
      wrPrcr = 1'b0;
      wrPort = 1'b0;
      wrVolt = 1'b0;
      if (!regWr) begin
         wrCm0 = 1'b0;
      end else if (regAddr == OFS_CLOCK_CONTROL_REG_ZERO) begin
         wrCm0 = clockRegUnlock; // RULE17
      end else if (regAddr == OFS_CLOCK_CONTROL_REG_ONE) begin
         wrCm1 = clockRegUnlock; // RULE17
      end else if (regAddr == OFS_CLOCK_CONTROL_REG_TWO) begin
         wrCm2 = clockRegUnlock; // RULE17
      end else if (regAddr == OFS_PLL_CONTROL_REG) begin
         wrPlc0 = clockRegUnlock && !clockLockBit; // RULE1
      end else if (regAddr == OFS_POWER_MODE_REG_TWO) begin
         wrPm2 = modeRegUnlock; // RULE17
      end else if (regAddr == OFS_WRITE_PROTECT_REG) begin
         wrPrcr = 1'b1;
      end else if (regAddr == OFS_PORT_DIR_REG) begin
         wrPort = portRegUnlock; // RULE17
      end else if (regAddr == OFS_VOLTAGE_CTRL_REG) begin
         wrVolt = voltageRegUnlock; // RULE17
      end
   end

   // protect bits: clock, mode and voltage persist, port clears after one write
   unlock_bit #(.AUTO_CLEAR(1'b0)) clockUnlockBit (
      .mclk(mclk),
      .init(init),
      .protWrite(wrPrcr),
      .anyWrite(regWr),
      .newValue(regWdata[BIT_CLOCK_REG_UNLOCK]),
      .unlocked(clockRegUnlock)
   ); // RULE19
   unlock_bit #(.AUTO_CLEAR(1'b0)) modeUnlockBit (
      .mclk(mclk),
      .init(init),
      .protWrite(wrPrcr),
      .anyWrite(regWr),
      .newValue(regWdata[BIT_MODE_REG_UNLOCK]),
      .unlocked(modeRegUnlock)
   ); // RULE19
   // a write to the protect register itself rewrites the bit instead of consuming it
   unlock_bit #(.AUTO_CLEAR(1'b1)) portUnlockBit (
      .mclk(mclk),
      .init(init),
      .protWrite(wrPrcr),
      .anyWrite(regWr),
      .newValue(regWdata[BIT_PORT_REG_UNLOCK]),
      .unlocked(portRegUnlock)
   ); // RULE18
   unlock_bit #(.AUTO_CLEAR(1'b0)) voltageUnlockBit (
      .mclk(mclk),
      .init(init),
      .protWrite(wrPrcr),
      .anyWrite(regWr),
      .newValue(regWdata[BIT_VOLTAGE_REG_UNLOCK]),
      .unlocked(voltageRegUnlock)
   ); // RULE19

   // clock lock: only settable, so a runaway program cannot undo it
   always_ff @(posedge mclk) begin
      if (init) begin
         clockLockBit <= 1'b0;
      end else if (wrPm2 && regWdata[BIT_CLOCK_LOCK]) begin
         clockLockBit <= 1'b1;
      end
   end

   // register zero: guarded bits keep their value while locked
   always_ff @(posedge mclk) begin
      if (init) begin
         clockControlRegZero <= RST_CM0;
      end else if (wrCm0) begin
         if (clockLockBit) begin
            clockControlRegZero <= (clockControlRegZero & CM0_LOCK_MASK) |
               (regWdata & ~CM0_LOCK_MASK); // RULE1
         end else begin
            clockControlRegZero <= regWdata;
         end
      end
   end

   // register one: stop entry and pll select are guarded
   always_ff @(posedge mclk) begin
      if (init) begin
         clockControlRegOne <= RST_CM1;
      end else if (wrCm1) begin
         if (clockLockBit) begin
            clockControlRegOne <= (clockControlRegOne & CM1_LOCK_MASK) |
               (regWdata & ~CM1_LOCK_MASK); // RULE1
         end else begin
            clockControlRegOne <= regWdata;
         end
      end
   end

   // pll control register, every bit guarded by the decode above
   always_ff @(posedge mclk) begin
      if (init) begin
         pllCtrl <= RST_PLL_CONTROL_REG;
      end else if (wrPlc0) begin
         pllCtrl <= regWdata; // RULE1
      end
   end

   // port-direction and voltage-control registers behind their unlock bits
   always_ff @(posedge mclk) begin
      if (init) begin
         portDir <= RST_PLAIN;
      end else if (wrPort) begin
         portDir <= regWdata; // RULE21
      end
   end
   always_ff @(posedge mclk) begin
      if (init) begin
         voltageCtrl <= RST_PLAIN;
      end else if (wrVolt) begin
         voltageCtrl <= regWdata; // RULE21
      end
   end

   // detection enable, guarded by the clock lock
   always_ff @(posedge mclk) begin
      if (init) begin
         stopDetectEnable <= 1'b0;
      end else if (wrCm2 && !clockLockBit) begin
         stopDetectEnable <= regWdata[BIT_STOP_DETECT_ENABLE]; // RULE1
      end
   end

   // action select is plain read and write
   always_ff @(posedge mclk) begin
      if (init) begin
         detectActionSelect <= 1'b0;
      end else if (wrCm2) begin
         detectActionSelect <= regWdata[BIT_DETECT_ACTION_SELECT];
      end
   end

   // edge detector on the oscillator status
   osc_stop_detect stopDetector (
      .mclk(mclk),
      .init(init),
      .enable(stopDetectEnable),
      .mainClkAlive(mainClkAlive),
      .stopSeen(stopSeen),
      .restartSeen(restartSeen)
   ); // RULE4

   // the cpu source at the moment of the stop decides the reaction
   assign stopOnSub = stopSeen && detectActionSelect &&
      clockControlRegZero[BIT_SUB_CLOCK_SELECT];
   assign stopOnPll = stopSeen && detectActionSelect && !stopOnSub &&
      !internalOscSelect && clockControlRegOne[BIT_PLL_SYSTEM_SELECT];
   assign stopOnMain = stopSeen && detectActionSelect && !stopOnSub && !stopOnPll;
   // an event counts only while the flag is clear
   assign eventAccepted = (stopSeen || restartSeen) && detectActionSelect &&
      !stopDetectFlag; // RULE13

   // halting reset: held until a hardware reset, nothing else releases it
   always_ff @(posedge mclk) begin
      if (hwReset) begin
         oscStopResetHold <= 1'b0; // RULE7
      end else if (stopSeen && !detectActionSelect) begin
         oscStopResetHold <= 1'b1; // RULE6
      end
   end

   // interrupt request, one cycle per accepted event, shared vector with the watchdog
   always_ff @(posedge mclk) begin
      if (init) begin
         stopDetectIrq <= 1'b0;
      end else begin
         stopDetectIrq <= eventAccepted; // RULE12
      end
   end

   // flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (init) begin
         stopDetectFlag <= 1'b0;
      end else if (eventAccepted) begin
         stopDetectFlag <= 1'b1; // RULE9 RULE10 RULE11
      end else if (wrCm2 && !regWdata[BIT_STOP_DETECT_FLAG]) begin
         stopDetectFlag <= 1'b0; // RULE13
      end
   end

   // halted status follows the oscillator even while the flag holds off interrupts
   always_ff @(posedge mclk) begin
      if (init) begin
         mainClockHalted <= 1'b0;
      end else if (stopSeen && detectActionSelect) begin
         mainClockHalted <= 1'b1; // RULE9 RULE10
      end else if (restartSeen && detectActionSelect) begin
         mainClockHalted <= 1'b0; // RULE11
      end
   end

   // on-chip select: forced on a main-source stop, untouched by pll stop or restart
   always_ff @(posedge mclk) begin
      if (init) begin
         internalOscSelect <= 1'b0;
      end else if (stopOnMain && !stopDetectFlag) begin
         internalOscSelect <= 1'b1; // RULE9
      end else if (wrCm2) begin
         internalOscSelect <= regWdata[BIT_INTERNAL_OSC_SELECT]; // RULE10
      end
   end

   // low-speed fallback: peripherals leave the dead main clock, cpu stays on sub
   always_ff @(posedge mclk) begin
      if (init) begin
         lowSpeedFallback <= 1'b0;
      end else if (stopOnSub && !stopDetectFlag) begin
         lowSpeedFallback <= 1'b1; // RULE14
      end else if (wrCm2 && !regWdata[BIT_INTERNAL_OSC_SELECT]) begin
         lowSpeedFallback <= 1'b0;
      end
   end

   // clock source selection seen by the clock tree
   always_comb begin
      if (clockControlRegZero[BIT_SUB_CLOCK_SELECT]) begin
         cpuClkSrc = SRC_SUB; // RULE14
      end else if (internalOscSelect) begin
         cpuClkSrc = SRC_ONCHIP; // RULE9
      end else if (clockControlRegOne[BIT_PLL_SYSTEM_SELECT]) begin
         cpuClkSrc = SRC_PLL;
      end else begin
         cpuClkSrc = SRC_MAIN;
      end
      if (internalOscSelect || lowSpeedFallback) begin
         periphClkSrc = SRC_ONCHIP; // RULE9 RULE14
      end else begin
         periphClkSrc = SRC_MAIN;
      end
   end

   // on-chip oscillator runs whenever something draws from it
   assign onchipOscRun = internalOscSelect || lowSpeedFallback;

   // plain control outputs straight from the registers
   assign periphClkInWait = clockControlRegZero[BIT_PERIPH_CLK_IN_WAIT];
   assign mainOscOff = clockControlRegZero[BIT_MAIN_OSC_OFF];
   assign stopModeEntry = clockControlRegOne[BIT_STOP_MODE_ENTRY];

   // status register image, unused bits read zero
   always_comb begin
      clockControlRegTwo = RST_PLAIN;
      clockControlRegTwo[BIT_STOP_DETECT_ENABLE] = stopDetectEnable;
      clockControlRegTwo[BIT_INTERNAL_OSC_SELECT] = internalOscSelect;
      clockControlRegTwo[BIT_STOP_DETECT_FLAG] = stopDetectFlag;
      clockControlRegTwo[BIT_MAIN_CLOCK_HALTED] = mainClockHalted;
      clockControlRegTwo[BIT_DETECT_ACTION_SELECT] = detectActionSelect;
   end

   // read decoding; unmapped addresses read zero
   always_comb begin
      next_readValue = RST_PLAIN;
      if (regAddr == OFS_CLOCK_CONTROL_REG_ZERO) begin
         next_readValue = clockControlRegZero;
      end else if (regAddr == OFS_CLOCK_CONTROL_REG_ONE) begin
         next_readValue = clockControlRegOne;
      end else if (regAddr == OFS_CLOCK_CONTROL_REG_TWO) begin
         next_readValue = clockControlRegTwo;
      end else if (regAddr == OFS_PLL_CONTROL_REG) begin
         next_readValue = pllCtrl;
      end else if (regAddr == OFS_POWER_MODE_REG_TWO) begin
         next_readValue[BIT_CLOCK_LOCK] = clockLockBit;
      end else if (regAddr == OFS_WRITE_PROTECT_REG) begin
         next_readValue[BIT_CLOCK_REG_UNLOCK] = clockRegUnlock;
         next_readValue[BIT_MODE_REG_UNLOCK] = modeRegUnlock;
         next_readValue[BIT_PORT_REG_UNLOCK] = portRegUnlock;
         next_readValue[BIT_VOLTAGE_REG_UNLOCK] = voltageRegUnlock;
      end else if (regAddr == OFS_PORT_DIR_REG) begin
         next_readValue = portDir;
      end else if (regAddr == OFS_VOLTAGE_CTRL_REG) begin
         next_readValue = voltageCtrl;
      end
   end

   // read data stand one cycle after the strobe and only then
   always_ff @(posedge mclk) begin
      if (hwReset) begin
         regRdata <= RST_PLAIN;
      end else if (regRd) begin
         regRdata <= next_readValue;
      end else begin
         regRdata <= RST_PLAIN;
      end
   end
endmodule

/* File: core/clock_guard_pkg.sv */
// shared register map, field positions and reset values for the clock guard
package clock_guard_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [7:0] OFS_CLOCK_CONTROL_REG_ZERO = 8'h00;
   localparam logic [7:0] OFS_CLOCK_CONTROL_REG_ONE = 8'h01;
   localparam logic [7:0] OFS_CLOCK_CONTROL_REG_TWO = 8'h02;
   localparam logic [7:0] OFS_PLL_CONTROL_REG = 8'h03;
   localparam logic [7:0] OFS_POWER_MODE_REG_TWO = 8'h04;
   localparam logic [7:0] OFS_WRITE_PROTECT_REG = 8'h05;
   localparam logic [7:0] OFS_PORT_DIR_REG = 8'h06;
   localparam logic [7:0] OFS_VOLTAGE_CTRL_REG = 8'h07;
   // clock_control_reg_zero fields
   localparam int BIT_PERIPH_CLK_IN_WAIT = 2;
   localparam int BIT_MAIN_OSC_OFF = 5;
   localparam int BIT_SUB_CLOCK_SELECT = 7;
   localparam logic [7:0] CM0_LOCK_MASK = 8'ha4;
   // clock_control_reg_one fields
   localparam int BIT_STOP_MODE_ENTRY = 0;
   localparam int BIT_PLL_SYSTEM_SELECT = 1;
   localparam logic [7:0] CM1_LOCK_MASK = 8'h03;
   // clock_control_reg_two fields
   localparam int BIT_STOP_DETECT_ENABLE = 0;
   localparam int BIT_INTERNAL_OSC_SELECT = 1;
   localparam int BIT_STOP_DETECT_FLAG = 2;
   localparam int BIT_MAIN_CLOCK_HALTED = 3;
   localparam int BIT_DETECT_ACTION_SELECT = 7;
   // power_mode_reg_two and write_protect_reg fields
   localparam int BIT_CLOCK_LOCK = 1;
   localparam int BIT_CLOCK_REG_UNLOCK = 0;
   localparam int BIT_MODE_REG_UNLOCK = 1;
   localparam int BIT_PORT_REG_UNLOCK = 2;
   localparam int BIT_VOLTAGE_REG_UNLOCK = 3;
   // reset values
   localparam logic [7:0] RST_CM0 = 8'h08;
   localparam logic [7:0] RST_CM1 = 8'h20;
   localparam logic [7:0] RST_PLL_CONTROL_REG = 8'h12;
   localparam logic [7:0] RST_PLAIN = 8'h00;
   // clock source encodings seen at the outputs
   typedef enum logic [1:0] {SRC_MAIN, SRC_PLL, SRC_ONCHIP, SRC_SUB} clk_src_e;
endpackage

/* File: core/unlock_bit.sv */
// one protect unlock bit, with optional clear on the next register write
`timescale 1ns/1ps
module unlock_bit #(
   parameter bit AUTO_CLEAR = 1'b0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic init,
   // register write port
   input wire logic protWrite,
   input wire logic anyWrite,
   input wire logic newValue,
   // state
   output logic unlocked
);
   // a write that sets the bit is not the write that consumes it
   always_ff @(posedge mclk) begin
      if (init) begin
         unlocked <= 1'b0;
      end else if (protWrite) begin
         unlocked <= newValue;
      end else if (AUTO_CLEAR && anyWrite && unlocked) begin
         unlocked <= 1'b0;
      end
   end
endmodule

/* File: core/osc_stop_detect.sv */
// main oscillator stop and restart edge detector
`timescale 1ns/1ps
module osc_stop_detect (
   // clock and reset
   input wire logic mclk,
   input wire logic init,
   // detector control and oscillator status
   input wire logic enable,
   input wire logic mainClkAlive,
   // events
   output logic stopSeen,
   output logic restartSeen
);
   logic lastAlive;

   // remember the previous level even while disabled, so enabling gives no false edge
   always_ff @(posedge mclk) begin
      if (init) begin
         lastAlive <= 1'b1;
      end else begin
         lastAlive <= mainClkAlive;
      end
   end

   // events only while detection is enabled
   assign stopSeen = enable && lastAlive && !mainClkAlive;
   assign restartSeen = enable && !lastAlive && mainClkAlive;
endmodule

/* File: tb/clock_guard_monitor.sv */
// concurrent checks on the clock guard top-level ports
`timescale 1ns/1ps
module clock_guard_monitor
   import clock_guard_pkg::*;
(
   // clock and resets
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic hwReset2_n,
   // register write port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   // oscillator and detector
   input wire logic mainClkAlive,
   input wire logic stopDetectIrq,
   input wire logic oscStopResetHold,
   input wire logic onchipOscRun,
   input wire logic [1:0] cpuClkSrc,
   input wire logic [1:0] periphClkSrc,
   // register image
   input wire logic [DATA_W-1:0] portDir
);
   // either hardware reset silences every check
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || !hwReset2_n);

   property p_irq_pulse;
      stopDetectIrq |=> !stopDetectIrq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("detect request longer than one cycle");
   property p_irq_cause;
      stopDetectIrq |-> $past(mainClkAlive) != $past(mainClkAlive, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("detect request without an oscillator change");
   property p_hold_keep;
      oscStopResetHold |=> oscStopResetHold;
   endproperty
   a_hold_keep: assert property (p_hold_keep)
      else $error("halting reset ended without hardware reset");
   property p_hold_cause;
      $rose(oscStopResetHold) |-> $past(mainClkAlive, 2) && !$past(mainClkAlive);
   endproperty
   a_hold_cause: assert property (p_hold_cause)
      else $error("halting reset without a main clock stop");
   property p_fallback;
      stopDetectIrq && !$past(mainClkAlive) && $past(cpuClkSrc) == SRC_MAIN
         |-> onchipOscRun && cpuClkSrc == SRC_ONCHIP && periphClkSrc == SRC_ONCHIP;
   endproperty
   a_fallback: assert property (p_fallback)
      else $error("no on-chip fallback after main clock stop");
   property p_pll_keep;
      stopDetectIrq && $past(cpuClkSrc) == SRC_PLL |-> cpuClkSrc == SRC_PLL;
   endproperty
   a_pll_keep: assert property (p_pll_keep)
      else $error("pll source changed by detection");
   property p_sub_keep;
      stopDetectIrq && $past(cpuClkSrc) == SRC_SUB
         |-> cpuClkSrc == SRC_SUB && periphClkSrc == SRC_ONCHIP;
   endproperty
   a_sub_keep: assert property (p_sub_keep)
      else $error("low-speed stop handled wrongly");
   // a halting reset re-initialises the port register, so it is let off
   property p_port_write;
      $changed(portDir) && !$past(oscStopResetHold) |-> $past(regWr)
         && $past(regAddr) == OFS_PORT_DIR_REG && $past(regWdata) == portDir;
   endproperty
   a_port_write: assert property (p_port_write)
      else $error("port direction changed without its write");
endmodule

bind clock_guard_and_stop_detect clock_guard_monitor i_clock_guard_monitor (.*);

/* File: tb/main_osc_model.sv */
// behavioural main crystal oscillator with a start-up delay
`timescale 1ns/1ps
module main_osc_model #(
   parameter int FREQ_KHZ = 8000,
   parameter int START_CYC = 4
) (
   // clock and command from the bench
   input wire logic mclk,
   input wire logic run,
   // oscillation status seen by the block
   output logic mainClkAlive
);
   int ramp = 0;
   initial mainClkAlive = 1'b0;
   // dies at once, but needs a few cycles to build amplitude again
   always @(posedge mclk) begin
      if (!run) begin
         ramp <= 0;
         mainClkAlive <= 1'b0;
      end else if (ramp < START_CYC) begin
         ramp <= ramp + 1;
      end else begin
         mainClkAlive <= 1'b1;
      end
   end
endmodule

/* File: tb/clock_guard_and_stop_detect_test.sv */
// self-checking bench for the clock guard and stop detector
`timescale 1ns/1ps
module clock_guard_and_stop_detect_test;
   import clock_guard_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hwReset2_n = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic oscRun = 1'b1;
   logic [7:0] regRdata, pllCtrl, portDir, voltageCtrl, rv;
   logic mainClkAlive, stopDetectIrq, oscStopResetHold, onchipOscRun, hit;
   logic [1:0] cpuClkSrc, periphClkSrc;
   int n_mismatch = 0;
   int tests_run = 0;

   // 125 MHz system clock
   always #4 mclk = ~mclk;

   clock_guard_and_stop_detect i_clock_guard_and_stop_detect (.*, .periphClkInWait(),
      .mainOscOff(), .stopModeEntry());
   main_osc_model i_main_osc_model (.mclk(mclk), .run(oscRun), .mainClkAlive(mainClkAlive));

   task automatic close_out();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bus cycles start at a rising edge and end on one
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWr <= 1'b1;
      regRd <= 1'b0;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regWr <= 1'b0;
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      @(negedge mclk);
      d = regRdata;
      @(posedge mclk);
   endtask
   task automatic idle(input int n);
      regWr <= 1'b0;
      regRd <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   // one-cycle request, so looked for at each falling edge
   task automatic wait_irq(input int n, output logic got);
      got = 1'b0;
      idle(0);
      repeat (n) begin
         @(negedge mclk);
         if (stopDetectIrq === 1'b1) got = 1'b1;
      end
      @(posedge mclk);
   endtask
   task automatic do_reset();
      idle(0);
      oscRun <= 1'b1;
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask

   task automatic t_reset_map();
      logic [7:0] exp [8];
      exp = '{RST_CM0, RST_CM1, RST_PLAIN, RST_PLL_CONTROL_REG, RST_PLAIN, RST_PLAIN, RST_PLAIN, RST_PLAIN};
      for (int i = 0; i < 8; i++) begin
         rd(8'(i), rv);
         check(rv, exp[i]);
      end
      rd(8'h20, rv);
      check(rv, 8'h00);
   endtask
   task automatic t_protect();
      wr(OFS_PLL_CONTROL_REG, 8'h33);
      wr(OFS_VOLTAGE_CTRL_REG, 8'h5a);
      rd(OFS_PLL_CONTROL_REG, rv);
      check(rv, RST_PLL_CONTROL_REG);
      rd(OFS_VOLTAGE_CTRL_REG, rv);
      check(rv, RST_PLAIN);
      wr(OFS_WRITE_PROTECT_REG, 8'h0f);
      wr(OFS_PORT_DIR_REG, 8'ha5);
      wr(OFS_PORT_DIR_REG, 8'h11);
      wr(OFS_VOLTAGE_CTRL_REG, 8'h3c);
      wr(OFS_PLL_CONTROL_REG, 8'h44);
      rd(OFS_PORT_DIR_REG, rv);
      check(rv, 8'ha5);
      rd(OFS_VOLTAGE_CTRL_REG, rv);
      check(rv, 8'h3c);
      rd(OFS_PLL_CONTROL_REG, rv);
      check(rv, 8'h44);
      rd(OFS_WRITE_PROTECT_REG, rv);
      check(rv & 8'h0f, 8'h0b);
      // a refused write still spends the port unlock
      wr(OFS_WRITE_PROTECT_REG, 8'h04);
      wr(OFS_VOLTAGE_CTRL_REG, 8'h3d);
      wr(OFS_PORT_DIR_REG, 8'h22);
      rd(OFS_PORT_DIR_REG, rv);
      check(rv, 8'ha5);
      rd(OFS_VOLTAGE_CTRL_REG, rv);
      check(rv, 8'h3c);
   endtask
   task automatic t_lock();
      wr(OFS_WRITE_PROTECT_REG, 8'h03);
      wr(OFS_POWER_MODE_REG_TWO, 8'h02);
      wr(OFS_WRITE_PROTECT_REG, 8'h01);
      wr(OFS_CLOCK_CONTROL_REG_ZERO, 8'hff);
      wr(OFS_CLOCK_CONTROL_REG_ONE, 8'hff);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h01);
      wr(OFS_PLL_CONTROL_REG, 8'h00);
      rd(OFS_CLOCK_CONTROL_REG_ZERO, rv);
      check(rv & CM0_LOCK_MASK, RST_CM0 & CM0_LOCK_MASK);
      rd(OFS_CLOCK_CONTROL_REG_ONE, rv);
      check(rv & CM1_LOCK_MASK, RST_CM1 & CM1_LOCK_MASK);
      rd(OFS_CLOCK_CONTROL_REG_TWO, rv);
      check(8'(rv[BIT_STOP_DETECT_ENABLE]), 8'h00);
      rd(OFS_PLL_CONTROL_REG, rv);
      check(rv, 8'h44);
   endtask
   task automatic t_detect_main();
      wr(OFS_WRITE_PROTECT_REG, 8'h01);
      oscRun <= 1'b0;
      wait_irq(12, hit);
      check(8'(hit), 8'h00);
      oscRun <= 1'b1;
      idle(8);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h81);
      oscRun <= 1'b0;
      wait_irq(8, hit);
      check(8'(hit), 8'h01);
      @(negedge mclk);
      check(8'(cpuClkSrc), 8'(SRC_ONCHIP));
      check(8'(periphClkSrc), 8'(SRC_ONCHIP));
      check(8'(onchipOscRun), 8'h01);
      @(posedge mclk);
      rd(OFS_CLOCK_CONTROL_REG_TWO, rv);
      check(rv & 8'h0e, 8'h0e);
      oscRun <= 1'b1;
      wait_irq(12, hit);
      check(8'(hit), 8'h00);
      rd(OFS_CLOCK_CONTROL_REG_TWO, rv);
      check(rv & 8'h0e, 8'h06);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h83);
      oscRun <= 1'b0;
      wait_irq(8, hit);
      check(8'(hit), 8'h01);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h83);
      oscRun <= 1'b1;
      wait_irq(12, hit);
      check(8'(hit), 8'h01);
      rd(OFS_CLOCK_CONTROL_REG_TWO, rv);
      check(rv & 8'h0e, 8'h06);
   endtask
   task automatic t_pll();
      wr(OFS_WRITE_PROTECT_REG, 8'h01);
      wr(OFS_CLOCK_CONTROL_REG_ONE, RST_CM1 | 8'h02);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h81);
      oscRun <= 1'b0;
      wait_irq(8, hit);
      check(8'(hit), 8'h01);
      rd(OFS_CLOCK_CONTROL_REG_TWO, rv);
      check(rv & 8'h0e, 8'h0c);
      check(8'(cpuClkSrc), 8'(SRC_PLL));
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h87);
      idle(1);
      @(negedge mclk);
      check(8'(cpuClkSrc), 8'(SRC_ONCHIP));
      @(posedge mclk);
   endtask
   task automatic t_sub();
      wr(OFS_WRITE_PROTECT_REG, 8'h01);
      wr(OFS_CLOCK_CONTROL_REG_ZERO, RST_CM0 | 8'h80);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h81);
      oscRun <= 1'b0;
      wait_irq(8, hit);
      check(8'(hit), 8'h01);
      @(negedge mclk);
      check(8'(cpuClkSrc), 8'(SRC_SUB));
      check(8'(periphClkSrc), 8'(SRC_ONCHIP));
      @(posedge mclk);
   endtask
   task automatic t_halt();
      wr(OFS_WRITE_PROTECT_REG, 8'h01);
      wr(OFS_PLL_CONTROL_REG, 8'h55);
      wr(OFS_CLOCK_CONTROL_REG_TWO, 8'h01);
      oscRun <= 1'b0;
      idle(6);
      oscRun <= 1'b1;
      idle(10);
      @(negedge mclk);
      check(8'(oscStopResetHold), 8'h01);
      check(pllCtrl, RST_PLL_CONTROL_REG);
      @(posedge mclk);
      hwReset2_n <= 1'b0;
      repeat (2) @(posedge mclk);
      hwReset2_n <= 1'b1;
      @(negedge mclk);
      check(8'(oscStopResetHold), 8'h00);
      @(posedge mclk);
   endtask

   // main sequence, reset between groups that leave lasting state behind
   initial begin
      do_reset();
      t_reset_map();
      t_protect();
      t_lock();
      do_reset();
      rd(OFS_POWER_MODE_REG_TWO, rv);
      check(8'(rv[BIT_CLOCK_LOCK]), 8'h00);
      t_detect_main();
      do_reset();
      t_pll();
      do_reset();
      t_sub();
      do_reset();
      t_halt();
      close_out();
   end
   // the sequence needs a few hundred cycles, so this is a hang
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end
endmodule
